// ### acr_pkg.sv
/*
  Package for the converter control and result register block: register
  offsets, field positions, reset values, state codes and carrier structs.
  Assumes a byte-wide register port with a 3-bit address.
*/
package acr_pkg;

  // register offsets on the byte-wide register port
  localparam logic [2:0] ACR_OFF_RESULT_LOW = 3'h0;
  localparam logic [2:0] ACR_OFF_RESULT_HIGH = 3'h1;
  localparam logic [2:0] ACR_OFF_CONV_MAIN = 3'h2;
  localparam logic [2:0] ACR_OFF_SRC_CLK = 3'h3;
  localparam logic [2:0] ACR_OFF_REF_GAIN = 3'h4;
  localparam logic [2:0] ACR_OFF_BANDGAP = 3'h5;

  // conv_control_main field positions
  localparam int ACR_MAIN_START_BIT = 7;
  localparam int ACR_MAIN_BUSY_BIT = 6;
  localparam int ACR_MAIN_ENABLE_BIT = 5;
  localparam int ACR_MAIN_ALIGN_BIT = 4;
  localparam int ACR_MAIN_CHAN_LSB = 0;
  // conv_source_clock_select field positions
  localparam int ACR_SRC_SOURCE_LSB = 4;
  localparam int ACR_SRC_DIV_LSB = 0;
  // conv_reference_gain_control field positions
  localparam int ACR_REF_AMP_EN_BIT = 7;
  localparam int ACR_REF_AMP_IN_BIT = 4;
  localparam int ACR_REF_VREF_LSB = 2;
  localparam int ACR_REF_GAIN_LSB = 0;
  // bandgap_control field position
  localparam int ACR_BG_ENABLE_BIT = 0;

  // widths
  localparam int ACR_RESULT_W = 12;
  localparam int ACR_DIV_CNT_W = 7;

  // reset values
  localparam logic [7:0] ACR_RST_BYTE = 8'h00;
  localparam logic [11:0] ACR_RST_RESULT = 12'h000;
  localparam logic [6:0] ACR_RST_DIV_CNT = 7'h00;

  // conversion state, one-hot
  typedef enum logic [1:0] {
    ACR_IDLE = 2'b01,
    ACR_BUSY = 2'b10
  } acr_state_t;

  // software settings of conv_control_main
  typedef struct packed {
    logic start;
    logic enable;
    logic align;
    logic [3:0] chan;
  } acr_main_t;

  // software settings of conv_source_clock_select
  typedef struct packed {
    logic [3:0] source;
    logic [2:0] div;
  } acr_src_t;

  // analog reference, gain amplifier and bandgap settings
  typedef struct packed {
    logic gain_amp_enable;
    logic gain_amp_input_select;
    logic [1:0] reference_select;
    logic [1:0] gain_amp_gain_select;
    logic bandgap_enable;
  } acr_analog_cfg_t;

  localparam acr_main_t ACR_RST_MAIN = '0;
  localparam acr_src_t ACR_RST_SRC = '0;
  localparam acr_analog_cfg_t ACR_RST_ANALOG = '0;

endpackage

// ### acr_top.sv
/*
  Converter control and result registers for one shared 12-bit converter.
  Holds the control registers, starts conversions, divides the conversion
  clock, captures results and steers channel routing and pin functions.
  Assumes the analog core runs on mclk_i, counts conv_tick_o pulses and
  returns core_done_i with core_data_i; pin-mux selects arrive on mclk_i.
*/
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RQ1: each conversion yields a 12-bit result
// RQ2: internal source disconnects the external channel
// RQ3: source and channel fields pick the signal
// RQ4: alignment zero: high byte bits 11..4
// RQ5: alignment one: low byte bits 7..0
// RQ6: unused result bit positions read zero
// RQ7: converter disabled keeps result bytes unchanged
// RQ8: analog pin loses digital and shared functions
// RQ9: analog pin loses its pull-up
// RQ10: main control register field layout
// RQ11: source and clock register field layout
// RQ12: reference and gain register field layout
// RQ13: bandgap register holds enable at bit 0
// RQ14: one converter, one signal at a time
// RQ15: software writes start high then low
// RQ16: busy read-only, set on start, cleared done
// RQ17: conversion clock is fsys over power two
// RQ18: enable needed for conversions, clear powers down
// RQ19: both result bytes update together at completion
// RQ20: all control fields reset to zero
module acr_top import acr_pkg::*; (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic core_done_i,
  input wire logic [11:0] core_data_i,
  input wire logic [15:0] analog_pin_sel_i,
  input wire logic [15:0] pullup_cfg_i,
  output logic core_enable_o,
  output logic core_start_o,
  output logic conv_tick_o,
  output logic ext_connect_o,
  output logic [3:0] channel_sel_o,
  output logic [3:0] source_sel_o,
  output acr_analog_cfg_t analog_cfg_o,
  output logic [15:0] gpio_disable_o,
  output logic [15:0] pullup_en_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  acr_main_t main_reg, next_main_reg;
  acr_src_t src_reg, next_src_reg;
  acr_analog_cfg_t ana_reg, next_ana_reg;
  acr_state_t state, next_state;
  logic [11:0] result, next_result;
  logic [6:0] div_cnt, next_div_cnt;
  logic [7:0] next_rdata;
  logic next_core_start, next_conv_tick, next_ext_connect;
  logic [15:0] next_gpio_disable, next_pullup_en;
  logic wr_main, start_fall, src_internal, busy;
  logic [6:0] div_mask;

  assign busy = (state == ACR_BUSY);
  assign wr_main = wr_i && (addr_i == ACR_OFF_CONV_MAIN);
  // start is taken on the write that returns the start bit to low
  assign start_fall = wr_main && main_reg.start && !wdata_i[ACR_MAIN_START_BIT]; // RQ15
  // codes 0000, 0100 and 11xx pick the external channel, all else internal
  assign src_internal = !((src_reg.source == 4'h0) || (src_reg.source == 4'h4)
                          || (src_reg.source[3:2] == 2'b11)); // RQ3
  // mask of divider bits that must all be ones for a tick
  assign div_mask = 7'((8'h01 << src_reg.div) - 8'h01); // RQ17

  ////////////////////////////////////////////////////////////////////////////
  // control registers: only implemented bits are stored
  always_comb begin
    next_main_reg = main_reg;
    next_src_reg = src_reg;
    next_ana_reg = ana_reg;
    if (wr_main) begin
      next_main_reg.start = wdata_i[ACR_MAIN_START_BIT]; // RQ10
      next_main_reg.enable = wdata_i[ACR_MAIN_ENABLE_BIT];
      next_main_reg.align = wdata_i[ACR_MAIN_ALIGN_BIT];
      next_main_reg.chan = wdata_i[ACR_MAIN_CHAN_LSB +: 4];
    end
    if (wr_i && (addr_i == ACR_OFF_SRC_CLK)) begin
      next_src_reg.source = wdata_i[ACR_SRC_SOURCE_LSB +: 4]; // RQ11
      next_src_reg.div = wdata_i[ACR_SRC_DIV_LSB +: 3];
    end
    if (wr_i && (addr_i == ACR_OFF_REF_GAIN)) begin
      next_ana_reg.gain_amp_enable = wdata_i[ACR_REF_AMP_EN_BIT]; // RQ12
      next_ana_reg.gain_amp_input_select = wdata_i[ACR_REF_AMP_IN_BIT];
      next_ana_reg.reference_select = wdata_i[ACR_REF_VREF_LSB +: 2];
      next_ana_reg.gain_amp_gain_select = wdata_i[ACR_REF_GAIN_LSB +: 2];
    end
    if (wr_i && (addr_i == ACR_OFF_BANDGAP)) begin
      next_ana_reg.bandgap_enable = wdata_i[ACR_BG_ENABLE_BIT]; // RQ13
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      main_reg <= ACR_RST_MAIN; // RQ20
      src_reg <= ACR_RST_SRC;
      ana_reg <= ACR_RST_ANALOG;
    end else begin
      main_reg <= next_main_reg;
      src_reg <= next_src_reg;
      ana_reg <= next_ana_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer: a single converter, so a new start while busy is
  // ignored rather than queued
  always_comb begin
    next_state = state;
    next_result = result;
    next_core_start = 1'b0;
    case (state)
      ACR_IDLE: begin
        if (start_fall && main_reg.enable) begin // RQ18
          next_state = ACR_BUSY; // RQ16
          next_core_start = 1'b1; // RQ14
        end
      end
      ACR_BUSY: begin
        if (!main_reg.enable) begin
          next_state = ACR_IDLE; // RQ7
        end else if (core_done_i) begin
          next_result = core_data_i; // RQ1 RQ19
          next_state = ACR_IDLE; // RQ16
        end
      end
      default: begin
        next_state = ACR_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state <= ACR_IDLE;
      result <= ACR_RST_RESULT;
      core_start_o <= 1'b0;
    end else begin
      state <= next_state;
      result <= next_result;
      core_start_o <= next_core_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion clock divider: counter cleared while idle, tick when masked bits all ones;
  // ticks only while busy so the core idles between conversions
  always_comb begin
    next_div_cnt = busy ? 7'(div_cnt + 7'h01) : ACR_RST_DIV_CNT;
    next_conv_tick = busy && ((div_cnt & div_mask) == div_mask); // RQ17
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      div_cnt <= ACR_RST_DIV_CNT;
      conv_tick_o <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      conv_tick_o <= next_conv_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // routing and pin functions, registered so the outputs are clean
  always_comb begin
    next_ext_connect = main_reg.enable && !src_internal; // RQ2 RQ3
    next_gpio_disable = analog_pin_sel_i; // RQ8
    next_pullup_en = pullup_cfg_i & ~analog_pin_sel_i; // RQ9
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ext_connect_o <= 1'b0;
      gpio_disable_o <= 16'h0000;
      pullup_en_o <= 16'h0000;
    end else begin
      ext_connect_o <= next_ext_connect;
      gpio_disable_o <= next_gpio_disable;
      pullup_en_o <= next_pullup_en;
    end
  end

  assign core_enable_o = main_reg.enable; // RQ18
  assign channel_sel_o = main_reg.chan;
  assign source_sel_o = src_reg.source;
  assign analog_cfg_o = ana_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the read strobe; unmapped offsets read zero
  always_comb begin
    next_rdata = ACR_RST_BYTE;
    if (rd_i) begin
      case (addr_i)
        ACR_OFF_RESULT_LOW: begin
          next_rdata = main_reg.align ? result[7:0] : {result[3:0], 4'h0}; // RQ4 RQ5 RQ6
        end
        ACR_OFF_RESULT_HIGH: begin
          next_rdata = main_reg.align ? {4'h0, result[11:8]} : result[11:4]; // RQ4 RQ5 RQ6
        end
        ACR_OFF_CONV_MAIN: begin
          next_rdata = {main_reg.start, busy, main_reg.enable, main_reg.align, main_reg.chan}; // RQ10 RQ16
        end
        ACR_OFF_SRC_CLK: begin
          next_rdata = {src_reg.source, 1'b0, src_reg.div}; // RQ11
        end
        ACR_OFF_REF_GAIN: begin
          next_rdata = {ana_reg.gain_amp_enable, 2'b00, ana_reg.gain_amp_input_select,
                        ana_reg.reference_select, ana_reg.gain_amp_gain_select}; // RQ12
        end
        ACR_OFF_BANDGAP: begin
          next_rdata = {7'h00, ana_reg.bandgap_enable}; // RQ13
        end
        default: begin
          next_rdata = ACR_RST_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_o <= ACR_RST_BYTE;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_start_taken;
    state == ACR_IDLE && start_fall && main_reg.enable;
  endsequence

  sequence s_done_taken;
    busy && main_reg.enable && core_done_i;
  endsequence

  property p_busy_on_start;
    @(posedge mclk_i) disable iff (srst_i)
      s_start_taken |=> busy && core_start_o ##1 !core_start_o;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) else $error("start did not raise busy"); // RQ16

  property p_result_on_done;
    @(posedge mclk_i) disable iff (srst_i)
      s_done_taken |=> !busy && result == $past(core_data_i);
  endproperty
  a_result_on_done: assert property (p_result_on_done) else $error("result not captured at done"); // RQ19

  property p_hold_when_off;
    @(posedge mclk_i) disable iff (srst_i)
      !main_reg.enable |=> $stable(result);
  endproperty
  a_hold_when_off: assert property (p_hold_when_off) else $error("result changed while disabled"); // RQ7

  property p_no_start_when_off;
    @(posedge mclk_i) disable iff (srst_i)
      (!busy && !main_reg.enable) |=> !busy;
  endproperty
  a_no_start_when_off: assert property (p_no_start_when_off) else $error("busy while disabled"); // RQ18

  property p_ext_off_internal;
    @(posedge mclk_i) disable iff (srst_i)
      src_internal |=> !ext_connect_o;
  endproperty
  a_ext_off_internal: assert property (p_ext_off_internal) else $error("external channel left on"); // RQ2

  property p_pin_functions;
    @(posedge mclk_i) disable iff (srst_i)
      1'b1 |=> gpio_disable_o == $past(analog_pin_sel_i) && (pullup_en_o & gpio_disable_o) == 16'h0000;
  endproperty
  a_pin_functions: assert property (p_pin_functions) else $error("analog pin keeps digital use"); // RQ9

  property p_read_align0;
    @(posedge mclk_i) disable iff (srst_i)
      rd_i && addr_i == ACR_OFF_RESULT_HIGH && !main_reg.align |=> rdata_o == $past(result[11:4]);
  endproperty
  a_read_align0: assert property (p_read_align0) else $error("high byte wrong, align 0"); // RQ4

  property p_read_align1;
    @(posedge mclk_i) disable iff (srst_i)
      rd_i && addr_i == ACR_OFF_RESULT_LOW && main_reg.align |=> rdata_o == $past(result[7:0]);
  endproperty
  a_read_align1: assert property (p_read_align1) else $error("low byte wrong, align 1"); // RQ5

  property p_undivided_tick;
    @(posedge mclk_i) disable iff (srst_i)
      busy && src_reg.div == 3'h0 |=> conv_tick_o;
  endproperty
  a_undivided_tick: assert property (p_undivided_tick) else $error("no tick at divide by one"); // RQ17

endmodule

`default_nettype wire

// ### acr_top_bench.sv
/*
  Self-checking bench for acr_top: register port, core handshake and pins.
  Assumes the bench plays the analog core: it pulses done with a result.
*/
`timescale 1ns/1ps
`default_nettype none
module acr_top_bench import acr_pkg::*; ;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic core_done_i = 1'b0;
  logic [11:0] core_data_i = 12'h000;
  logic [15:0] analog_pin_sel_i = 16'h0000;
  logic [15:0] pullup_cfg_i = 16'h0000;
  logic core_enable_o, core_start_o, conv_tick_o, ext_connect_o;
  logic [3:0] channel_sel_o, source_sel_o;
  acr_analog_cfg_t analog_cfg_o;
  logic [15:0] gpio_disable_o, pullup_en_o;
  int n_mismatch = 0;
  int cmp_count = 0;
  int i, e, ticks;
  integer seed = 47;
  logic [15:0] exq[$];
  logic rd_pend = 1'b0;
  logic [7:0] r, m;
  logic [11:0] d, dl;
  logic [15:0] p, u;

  // 100 ns period
  always #50 mclk_i = ~mclk_i;

  acr_top DUT (.mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .core_done_i(core_done_i), .core_data_i(core_data_i),
    .analog_pin_sel_i(analog_pin_sel_i), .pullup_cfg_i(pullup_cfg_i), .core_enable_o(core_enable_o),
    .core_start_o(core_start_o), .conv_tick_o(conv_tick_o), .ext_connect_o(ext_connect_o),
    .channel_sel_o(channel_sel_o), .source_sel_o(source_sel_o), .analog_cfg_o(analog_cfg_o),
    .gpio_disable_o(gpio_disable_o), .pullup_en_o(pullup_en_o));

  ////////////////////////////////////////////////////////////////////////////////
  // one comparison; case inequality so an unknown never matches
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compares %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one bus cycle per edge, so no strobe is assigned twice in a step
  task automatic bus(input logic w, input logic rr, input logic [2:0] a, input logic [7:0] wd);
    @(posedge mclk_i);
    wr_i <= w;
    rd_i <= rr;
    addr_i <= a;
    wdata_i <= wd;
  endtask

  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 3'h0, 8'h00);
  endtask

  // the note goes in before the strobe, the monitor takes it off later
  task automatic rdx(input logic [2:0] a, input logic [7:0] ex);
    exq.push_back(16'(ex));
    bus(1'b0, 1'b1, a, 8'h00);
  endtask

  // core answer; data turns to its inverse once done drops
  task automatic done(input logic [11:0] dd);
    @(posedge mclk_i);
    core_done_i <= 1'b1;
    core_data_i <= dd;
    @(posedge mclk_i);
    core_done_i <= 1'b0;
    core_data_i <= ~dd;
  endtask

  // start high then low; the core pulse is expected only when enabled
  task automatic start(input logic [7:0] mm);
    bus(1'b1, 1'b0, ACR_OFF_CONV_MAIN, 8'h80 | mm);
    bus(1'b1, 1'b0, ACR_OFF_CONV_MAIN, mm);
    idle(1);
    #1 check(16'(core_start_o), 16'(mm[5]));
  endtask

  task automatic res(input logic al, input logic [11:0] dd);
    rdx(ACR_OFF_RESULT_LOW, al ? dd[7:0] : {dd[3:0], 4'h0});
    rdx(ACR_OFF_RESULT_HIGH, al ? {4'h0, dd[11:8]} : dd[11:4]);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // read monitor: data stands only in the cycle after the strobe
  always @(posedge mclk_i) rd_pend <= rd_i;
  always @(negedge mclk_i) begin
    if (rd_pend) check(16'(rdata_o), exq.pop_front());
  end

  // watchdog, far beyond the few thousand cycles the tests need
  initial begin
    #2_000_000;
    n_mismatch++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk_i);
    srst_i <= 1'b0;
    for (i = 0; i < 8; i++) rdx(3'(i), 8'h00);
    idle(1);
    check(16'({core_enable_o, conv_tick_o, ext_connect_o, channel_sel_o, source_sel_o}), 16'h0000);
    $display("test reset done");
    // reserved bits read zero, the low result byte and offset 6 ignore writes
    r = 8'($random(seed));
    for (i = 0; i < 8; i++) if (i != 2) bus(1'b1, 1'b0, 3'(i), r);
    rdx(ACR_OFF_SRC_CLK, r & 8'hF7);
    rdx(ACR_OFF_REF_GAIN, r & 8'h9F);
    rdx(ACR_OFF_BANDGAP, r & 8'h01);
    rdx(ACR_OFF_RESULT_LOW, 8'h00);
    rdx(3'h6, 8'h00);
    idle(2);
    check(16'(analog_cfg_o), 16'({r[7], r[4], r[3:2], r[1:0], r[0]}));
    check(16'(source_sel_o), 16'(r[7:4]));
    bus(1'b1, 1'b0, ACR_OFF_SRC_CLK, 8'h00);
    $display("test layout done");
    // one conversion in each alignment, random result and channel
    for (i = 0; i < 2; i++) begin
      d = 12'($random(seed));
      m = 8'h20 | 8'(i << 4) | 8'($random(seed) & 15);
      start(m);
      rdx(ACR_OFF_CONV_MAIN, m | 8'h40);
      idle(1);
      check(16'(channel_sel_o), 16'(m[3:0]));
      check(16'(core_enable_o), 16'h0001);
      done(d);
      idle(1);
      rdx(ACR_OFF_CONV_MAIN, m);
      res(i[0], d);
      dl = d;
    end
    $display("test convert done");
    // disabled: start ignored, stray done ignored, result kept
    bus(1'b1, 1'b0, ACR_OFF_CONV_MAIN, 8'h10);
    start(8'h10);
    done(~dl);
    rdx(ACR_OFF_CONV_MAIN, 8'h10);
    res(1'b1, dl);
    // abort by clearing enable mid-conversion
    start(8'h30);
    bus(1'b1, 1'b0, ACR_OFF_CONV_MAIN, 8'h10);
    // drop the write strobe before the core answers, strobes stay one cycle
    idle(1);
    done(~dl);
    rdx(ACR_OFF_CONV_MAIN, 8'h10);
    res(1'b1, dl);
    $display("test disable done");
    // every source code: internal ones cut the external channel
    bus(1'b1, 1'b0, ACR_OFF_CONV_MAIN, 8'h2A);
    for (i = 0; i < 16; i++) begin
      bus(1'b1, 1'b0, ACR_OFF_SRC_CLK, {4'(i), 4'h0});
      idle(3);
      check(16'(ext_connect_o), 16'(i == 0 || i == 4 || i >= 12));
      check(16'(source_sel_o), 16'(i));
    end
    $display("test source done");
    // analog pins drop digital function and pull-up
    repeat (4) begin
      p = 16'($random(seed));
      u = 16'($random(seed));
      @(posedge mclk_i);
      analog_pin_sel_i <= p;
      pullup_cfg_i <= u;
      idle(3);
      check(gpio_disable_o, p);
      check(pullup_en_o, u & ~p);
    end
    $display("test pins done");
    // each divider code: tick count over a fixed busy window
    for (i = 0; i < 8; i++) begin
      bus(1'b1, 1'b0, ACR_OFF_SRC_CLK, 8'(i));
      start(8'h20);
      ticks = 0;
      repeat (256) begin
        @(posedge mclk_i);
        #1 ticks += int'(conv_tick_o);
      end
      e = 256 >> i;
      // the window starts with the counter at zero, so the count is exact
      check(16'(ticks), 16'(e));
      done(12'h000);
      idle(1);
    end
    $display("test divider done");
    summarize();
  end
endmodule
`default_nettype wire
